/* File: rtl/rrc_top.sv */
/*
 * Reset and retention control: merges power-on, hardware, software and
 * sleep events into one reset per storage class.
 * Assumes all inputs are synchronous to clk_sys and that the supply
 * monitors report a rail as ok while it is above its reset threshold.
 */
`timescale 1ns/1ps
`default_nettype none

`include "rrc_consts.svh"

// Contract
// - Analog or interface supply low raises power-on reset clearing all classes.
// - Reset pin low clears all registers, keeps sequencer, firmware per config.
// - Any reset trigger register write acts like the hardware reset.
// - Regulator off is sleep: keep always-on and sequencer, clear the rest.
// - Regulator stays enabled while its register bit or its pin is high.
// - Firmware survives reset only if core supply stays above threshold.
module rrc_top
   import rrc_pkg::*;
#(
   parameter int HOLD_CYCLES = `RRC_RST_HOLD_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic analog_supply_ok,
   input wire logic digital_interface_supply_ok,
   input wire logic core_supply_ok,
   input wire logic hw_reset_n,
   input wire logic reset_trigger_wr,
   input wire logic core_regulator_enable_bit,
   input wire logic regulator_enable_pin,
   input wire logic fw_retain_cfg,
   output logic core_regulator_en_q,
   output logic sleep_q,
   output rrc_cause_t cause_q,
   output logic rst_always_on_q,
   output logic rst_other_regs_q,
   output logic rst_seq_mem_q,
   output logic rst_fw_mem_q
);

   logic por_req;
   logic hard_req;
   logic soft_req;
   logic hwsw_req;
   logic sleep_req;
   logic fw_lost;
   logic ao_req;
   logic other_req;
   logic seq_req;
   logic fw_req;
   rrc_cause_t cause_d;

   assign por_req = rst | ~analog_supply_ok | ~digital_interface_supply_ok;
   assign hard_req = ~hw_reset_n;
   assign soft_req = reset_trigger_wr;
   assign hwsw_req = hard_req | soft_req;
   // Sleep follows the registered regulator state, so it lags by one cycle.
   assign sleep_req = ~core_regulator_en_q;
   // Firmware is lost if retention is off or the core rail dips in reset.
   assign fw_lost = hwsw_req & (~fw_retain_cfg | ~core_supply_ok);

   assign ao_req = por_req | hwsw_req;
   assign other_req = por_req | hwsw_req | sleep_req;
   assign seq_req = por_req;
   assign fw_req = por_req | fw_lost | sleep_req;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         core_regulator_en_q <= 1'b1;
      end else begin
         core_regulator_en_q <= core_regulator_enable_bit
                                | regulator_enable_pin;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sleep_q <= 1'b0;
      end else begin
         sleep_q <= sleep_req & ~por_req & ~hwsw_req;
      end
   end

   always_comb begin
      if (por_req) begin
         cause_d = RRC_CAUSE_POWER;
      end else if (hard_req) begin
         cause_d = RRC_CAUSE_HARD;
      end else if (soft_req) begin
         cause_d = RRC_CAUSE_SOFT;
      end else if (sleep_req) begin
         cause_d = RRC_CAUSE_SLEEP;
      end else begin
         cause_d = RRC_CAUSE_NONE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cause_q <= RRC_CAUSE_POWER;
      end else begin
         cause_q <= cause_d;
      end
   end

   rrc_stretch #(.HOLD_CYCLES(HOLD_CYCLES)) u_ao (
      .clk_sys(clk_sys),
      .rst(rst),
      .req(ao_req),
      .rst_q(rst_always_on_q)
   );

   rrc_stretch #(.HOLD_CYCLES(HOLD_CYCLES)) u_other (
      .clk_sys(clk_sys),
      .rst(rst),
      .req(other_req),
      .rst_q(rst_other_regs_q)
   );

   rrc_stretch #(.HOLD_CYCLES(HOLD_CYCLES)) u_seq (
      .clk_sys(clk_sys),
      .rst(rst),
      .req(seq_req),
      .rst_q(rst_seq_mem_q)
   );

   rrc_stretch #(.HOLD_CYCLES(HOLD_CYCLES)) u_fw (
      .clk_sys(clk_sys),
      .rst(rst),
      .req(fw_req),
      .rst_q(rst_fw_mem_q)
   );

   // Helper counters of quiet cycles since the last request of a class.
   localparam int QW = $clog2(HOLD_CYCLES + 2);
   localparam logic [QW-1:0] QMAX = QW'(HOLD_CYCLES + 1);

   logic [QW-1:0] seq_quiet_q;
   logic [QW-1:0] ao_quiet_q;
   logic [QW-1:0] fw_quiet_q;

   function automatic logic [QW-1:0] quiet_next(input logic req,
                                                input logic [QW-1:0] q);
      if (req) begin
         return '0;
      end else if (q != QMAX) begin
         return q + QW'(1);
      end else begin
         return q;
      end
   endfunction : quiet_next

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         seq_quiet_q <= '0;
         ao_quiet_q <= '0;
         fw_quiet_q <= '0;
      end else begin
         seq_quiet_q <= quiet_next(seq_req, seq_quiet_q);
         ao_quiet_q <= quiet_next(ao_req, ao_quiet_q);
         fw_quiet_q <= quiet_next(fw_req, fw_quiet_q);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence all_classes_reset;
      rst_always_on_q && rst_other_regs_q && rst_seq_mem_q && rst_fw_mem_q;
   endsequence

   sequence regs_reset;
      rst_always_on_q && rst_other_regs_q;
   endsequence

   sequence sleep_entry;
      !core_regulator_enable_bit && !regulator_enable_pin
         ##1 !por_req && !hwsw_req;
   endsequence

   power_on_clear_a: assert property (
      !analog_supply_ok || !digital_interface_supply_ok
         |=> all_classes_reset)
      else $error("Supply loss did not clear every class.");

   hard_reset_a: assert property (
      !hw_reset_n |=> regs_reset ##0 (seq_quiet_q != QMAX || !rst_seq_mem_q))
      else $error("Hardware reset wrong on registers or sequencer.");

   soft_reset_a: assert property (
      reset_trigger_wr && !por_req && !hard_req
         |=> regs_reset ##0 cause_q == RRC_CAUSE_SOFT)
      else $error("Software reset did not clear registers.");

   sleep_mode_a: assert property (
      sleep_entry |=> rst_other_regs_q && rst_fw_mem_q && sleep_q
         && cause_q == RRC_CAUSE_SLEEP
         && (ao_quiet_q != QMAX || !rst_always_on_q))
      else $error("Sleep entry cleared the wrong storage.");

   regulator_or_a: assert property (
      (core_regulator_enable_bit || regulator_enable_pin)
         |=> core_regulator_en_q ##1 !sleep_q)
      else $error("Regulator dropped while an enable was high.");

   regulator_off_a: assert property (
      !core_regulator_enable_bit && !regulator_enable_pin
         |=> !core_regulator_en_q)
      else $error("Regulator stayed on with both enables low.");

   fw_retention_a: assert property (
      hwsw_req && !core_supply_ok
         |=> rst_fw_mem_q ##1 (rst_fw_mem_q || HOLD_CYCLES < 2))
      else $error("Firmware kept across reset with core rail low.");

   fw_kept_a: assert property (
      fw_quiet_q == QMAX |-> !rst_fw_mem_q)
      else $error("Firmware memory reset with no cause.");

   precedence_a: assert property (
      por_req && hwsw_req |=> cause_q == RRC_CAUSE_POWER)
      else $error("Power-on reset lost precedence.");

endmodule : rrc_top

`default_nettype wire

/* File: rtl/rrc_consts.svh */
/*
 * Timing constants for the reset and retention control block.
 * Assumes the system clock period given here matches clk_sys.
 */
`ifndef RRC_CONSTS_SVH
`define RRC_CONSTS_SVH

`define RRC_CLK_PERIOD_NS 50
`define RRC_RST_HOLD_NS 200
`define RRC_RST_HOLD_CYCLES \
   ((`RRC_RST_HOLD_NS + `RRC_CLK_PERIOD_NS - 1) / `RRC_CLK_PERIOD_NS)

`endif

/* File: rtl/rrc_pkg.sv */
/*
 * Types shared by the reset and retention control block.
 * Assumes nothing of its surroundings.
 */
package rrc_pkg;

   typedef enum logic [2:0] {
      RRC_CAUSE_NONE,
      RRC_CAUSE_SLEEP,
      RRC_CAUSE_SOFT,
      RRC_CAUSE_HARD,
      RRC_CAUSE_POWER
   } rrc_cause_t;

endpackage : rrc_pkg

/* File: rtl/rrc_stretch.sv */
/*
 * Reset stretcher for one storage class.
 * Assumes the request is synchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module rrc_stretch #(
   parameter int HOLD_CYCLES = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic req,
   output logic rst_q
);

   localparam int CW = $clog2(HOLD_CYCLES + 1);

   logic [CW-1:0] cnt_q;

   if (HOLD_CYCLES < 1) begin : g_bad_hold
      $error("HOLD_CYCLES must be at least 1.");
   end

   // The class reset stays up for HOLD_CYCLES cycles after the request ends.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rst_q <= 1'b1;
         cnt_q <= CW'(HOLD_CYCLES - 1);
      end else if (req) begin
         rst_q <= 1'b1;
         cnt_q <= CW'(HOLD_CYCLES - 1);
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - CW'(1);
      end else begin
         rst_q <= 1'b0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   stretch_take_a: assert property (req |=> rst_q)
      else $error("Class reset did not follow its request.");
   stretch_hold_a: assert property (!req && cnt_q != '0 |=> rst_q)
      else $error("Class reset released before its hold time.");

endmodule : rrc_stretch

`default_nettype wire

/* File: sim/rrc_host.sv */
/*
 * Host model: supplies, reset pin, reset trigger write and enables.
 * Assumes the bench gives a random byte and a mode on each cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module rrc_host (
   input wire logic [7:0] rnd,
   input wire logic [1:0] mode,
   output logic analog_supply_ok,
   output logic digital_interface_supply_ok,
   output logic core_supply_ok,
   output logic hw_reset_n,
   output logic reset_trigger_wr,
   output logic core_regulator_enable_bit,
   output logic regulator_enable_pin,
   output logic fw_retain_cfg
);
   // Mode 1 holds sleep; mode 2 holds a reset while the core rail dips.
   always_comb begin
      regulator_enable_pin = (rnd[0] | rnd[1]) && mode != 2'h1;
      core_regulator_enable_bit = rnd[2] && mode != 2'h1;
      hw_reset_n = mode == 2'h1 || (mode != 2'h2 && !(&rnd[5:3]));
      if (!hw_reset_n) begin
         regulator_enable_pin = 1'b1;
      end
      reset_trigger_wr = mode != 2'h1 && (&rnd[7:5]);
      fw_retain_cfg = rnd[4] | mode == 2'h2;
      // The all-ones top bits also raise both resets, so events coincide.
      analog_supply_ok = !regulator_enable_pin |
         (rnd != 8'h13 && rnd[7:3] != 5'h1f);
      digital_interface_supply_ok = !regulator_enable_pin | rnd != 8'h37;
      core_supply_ok = (regulator_enable_pin | core_regulator_enable_bit) &&
         !(mode == 2'h2 && rnd[0]);
   end
endmodule : rrc_host

`default_nettype wire

/* File: sim/reset_retention_control_test.sv */
/*
 * Self-checking bench for rrc_top with a reference model per class.
 * Assumes rrc_host drives the device inputs from the random byte.
 */
`timescale 1ns/1ps
`default_nettype none

module reset_retention_control_test;
   import rrc_pkg::*;
   localparam int HOLD = 3;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic on = 1'b0;
   logic e_en = 1'b1;
   logic e_slp = 1'b0;
   logic [7:0] rnd = 8'h00;
   logic [1:0] mode = 2'h0;
   logic [31:0] seed = 32'h62;
   logic a_ok, d_ok, c_ok, hrn, twr, en_bit, en_pin, keep;
   logic reg_en, slp, aon, oth, seqm, fwm;
   rrc_cause_t cause, e_cause;
   int cnt [4];
   int err_total = 0;
   int n_compared = 0;

   rrc_host u_rrc_host (.rnd(rnd), .mode(mode), .analog_supply_ok(a_ok),
      .digital_interface_supply_ok(d_ok), .core_supply_ok(c_ok),
      .hw_reset_n(hrn), .reset_trigger_wr(twr),
      .core_regulator_enable_bit(en_bit), .regulator_enable_pin(en_pin),
      .fw_retain_cfg(keep));

   rrc_top #(.HOLD_CYCLES(HOLD)) u_rrc_top (.clk_sys(clk_sys), .rst(rst),
      .analog_supply_ok(a_ok), .digital_interface_supply_ok(d_ok),
      .core_supply_ok(c_ok), .hw_reset_n(hrn), .reset_trigger_wr(twr),
      .core_regulator_enable_bit(en_bit), .regulator_enable_pin(en_pin),
      .fw_retain_cfg(keep), .core_regulator_en_q(reg_en), .sleep_q(slp),
      .cause_q(cause), .rst_always_on_q(aon), .rst_other_regs_q(oth),
      .rst_seq_mem_q(seqm), .rst_fw_mem_q(fwm));

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs

   function automatic rrc_cause_t exp_cause(input logic pw, input logic hd,
                                            input logic sf, input logic sl);
      if (pw) begin
         return RRC_CAUSE_POWER;
      end else if (hd) begin
         return RRC_CAUSE_HARD;
      end else if (sf) begin
         return RRC_CAUSE_SOFT;
      end else if (sl) begin
         return RRC_CAUSE_SLEEP;
      end else begin
         return RRC_CAUSE_NONE;
      end
   endfunction : exp_cause

   task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   // Each class counter reloads on a request and counts down the hold.
   always @(posedge clk_sys) begin : model
      logic pw, hd, sf, sl;
      logic [3:0] rq;
      pw = rst | !a_ok | !d_ok;
      hd = !hrn;
      sf = twr;
      sl = !e_en;
      rq = {pw | sl | ((hd | sf) & (!keep | !c_ok)), pw, pw | hd | sf | sl,
         pw | hd | sf};
      for (int i = 0; i < 4; i++) begin
         cnt[i] = rq[i] ? HOLD : (cnt[i] > 0 ? cnt[i] - 1 : 0);
      end
      e_cause = exp_cause(pw, hd, sf, sl);
      e_slp = sl & !pw & !hd & !sf;
      e_en = rst | en_bit | en_pin;
      on = 1'b1;
   end

   always @(negedge clk_sys) begin
      if (on) begin
         chk(reg_en, e_en);
         chk(slp, e_slp);
         chk(cause, e_cause);
         chk(aon, cnt[0] != 0);
         chk(oth, cnt[1] != 0);
         chk(seqm, cnt[2] != 0);
         chk(fwm, cnt[3] != 0);
      end
   end

   task automatic run(input int n, input logic [1:0] m, input string name);
      repeat (n) begin
         @(posedge clk_sys);
         #1;
         seed = xs(seed);
         rnd = seed[7:0];
         mode = m;
      end
      $display("test %s done", name);
   endtask : run

   initial begin
      forever #25 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (100000) @(posedge clk_sys);
      err_total++;
      stop_test;
   end

   initial begin
      repeat (4) @(posedge clk_sys);
      #1 rst = 1'b0;
      run(2000, 2'h0, "random");
      run(20, 2'h1, "sleep hold");
      run(20, 2'h2, "reset with core dip");
      run(6, 2'h1, "sleep again");
      @(posedge clk_sys);
      #1 rst = 1'b1;
      run(3, 2'h0, "mid reset");
      rst = 1'b0;
      run(500, 2'h0, "random after reset");
      stop_test;
   end
endmodule : reset_retention_control_test

`default_nettype wire
